// ---- hdl/sfr_device.sv ----
// Flash-side command interpreter for latch, status and configuration registers.
`timescale 1ns/1ns
module sfr_device import sfr_pkg::*; #(
  parameter int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_CYC,
  parameter int unsigned NVCFG_WRITE_CYCLES = NVCFG_WRITE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire proto_t protoMode,
  input wire logic writeProtectN,
  sfr_link_if.dev link,
  output logic [7:0] statusOut_ff,
  output logic [7:0] flagOut_ff,
  output logic [15:0] nvCfgOut_ff,
  output logic [7:0] vCfgOut_ff,
  output logic [7:0] evCfgOut_ff
);
  // Link-clock domain.
  logic linkClr;
  logic inFrame_ff;
  logic [4:0] edgeCnt_ff;
  logic [15:0] inSh_ff;
  logic [7:0] opcode_ff;
  logic [2:0] obit_ff;
  logic [1:0] byteIdx_ff;
  logic [1:0] modeS1_ff;
  logic [1:0] modeS2_ff;
  logic [47:0] regS1_ff;
  logic [47:0] regS2_ff;
  logic [3:0] devOut_ff;
  logic [3:0] devOenN_ff;

  assign linkClr = rst | link.csN;
  assign link.devOut = devOut_ff;
  assign link.devOenN = devOenN_ff;

  wire proto_t linkMode = proto_t'(modeS2_ff);
  wire [4:0] opEdges = edgesPerByte(linkMode);
  wire [4:0] curCnt = inFrame_ff ? edgeCnt_ff : 5'h00;
  wire opPhase = curCnt < opEdges;
  wire opLast = (curCnt + 5'h01) == opEdges;
  wire [4:0] nxt_edgeCnt = (curCnt == EDGE_CNT_MAX) ? curCnt : curCnt + 5'h01;
  wire [15:0] nxt_inSh = shiftLanes(inSh_ff, link.lane, linkMode);
  wire [3:0] obitSum = {1'b0, obit_ff} + laneWidth(linkMode);
  wire byteWrap = obitSum[3] && (byteIdx_ff != 2'h3);
  wire [1:0] nxt_byteIdx = byteWrap ? byteIdx_ff + 2'h1 : byteIdx_ff;

  always_ff @(posedge link.sclk or posedge linkClr) begin
    if (linkClr) inFrame_ff <= 1'b0;
    else inFrame_ff <= 1'b1;
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      edgeCnt_ff <= 5'h00;
      inSh_ff <= 16'h0000;
      opcode_ff <= 8'h00;
      obit_ff <= 3'h0;
      byteIdx_ff <= 2'h0;
    end else begin
      edgeCnt_ff <= nxt_edgeCnt;
      inSh_ff <= nxt_inSh;
      if (opLast) opcode_ff <= nxt_inSh[7:0];
      obit_ff <= opPhase ? 3'h0 : obitSum[2:0];
      byteIdx_ff <= opPhase ? 2'h0 : nxt_byteIdx;
    end
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      modeS1_ff <= PROTO_EXT;
      modeS2_ff <= PROTO_EXT;
      regS1_ff <= 48'h0;
      regS2_ff <= 48'h0;
    end else begin
      modeS1_ff <= protoMode;
      modeS2_ff <= modeS1_ff;
      regS1_ff <= {statusOut_ff, flagOut_ff, nvCfgOut_ff, vCfgOut_ff, evCfgOut_ff};
      regS2_ff <= regS1_ff;
    end
  end

  wire [7:0] rdStat = regS2_ff[47:40];
  wire [7:0] rdFlag = regS2_ff[39:32];
  wire [15:0] rdNv = regS2_ff[31:16];
  wire [7:0] rdV = regS2_ff[15:8];
  wire [7:0] rdEv = regS2_ff[7:0];
  wire [7:0] nvByte = (byteIdx_ff == 2'h0) ? rdNv[7:0] :
                      (byteIdx_ff == 2'h1) ? rdNv[15:8] : 8'h00;
  wire isStat = opcode_ff == OP_RD_STAT;
  wire isFlag = opcode_ff == OP_RD_FLAG;
  wire isNv = opcode_ff == OP_RD_NVCFG;
  wire isV = opcode_ff == OP_RD_VCFG;
  wire isEv = opcode_ff == OP_RD_EVCFG;
  wire isRead = isStat | isFlag | isNv | isV | isEv;
  wire [7:0] curByte = isStat ? rdStat : isFlag ? rdFlag : isNv ? nvByte :
                       isV ? rdV : rdEv;
  wire [7:0] bitsOut = curByte << obit_ff;
  wire [3:0] laneOut = (linkMode == PROTO_DUAL) ? {2'b00, bitsOut[7:6]} :
                       (linkMode == PROTO_QUAD) ? bitsOut[7:4] : {2'b00, bitsOut[7], 1'b0};
  wire [3:0] laneOenN = (linkMode == PROTO_EXT) ? 4'hD : driveEnN(linkMode);
  wire driveNow = inFrame_ff & ~opPhase & isRead;

  always_ff @(negedge link.sclk or posedge linkClr) begin
    if (linkClr) begin
      devOut_ff <= 4'h0;
      devOenN_ff <= 4'hF;
    end else begin
      devOut_ff <= laneOut;
      devOenN_ff <= driveNow ? laneOenN : 4'hF;
    end
  end

  // System-clock domain; frame words are read only after select is seen high,
  // when the serial clock stands still and the link registers are stable.
  logic csS1_ff;
  logic csS2_ff;
  logic csS3_ff;
  logic wpS1_ff;
  logic wpS2_ff;
  logic [1:0] modeM1_ff;
  logic [1:0] modeM2_ff;
  logic welFf;
  logic busyFf;
  logic [5:0] statHiFf;
  logic [7:0] flagFf;
  logic [15:0] nvFf;
  logic [7:0] vFf;
  logic [7:0] evFf;
  logic pendNvFf;
  logic [15:0] pendValFf;
  logic [15:0] timerFf;
  logic nxt_wel;
  logic nxt_busy;
  logic [5:0] nxt_statHi;
  logic [7:0] nxt_flag;
  logic [15:0] nxt_nv;
  logic [7:0] nxt_v;
  logic [7:0] nxt_ev;
  logic nxt_pendNv;
  logic [15:0] nxt_pendVal;
  logic [15:0] nxt_timer;

  wire frameEnd = csS2_ff & ~csS3_ff;
  wire [4:0] sysOpEdges = edgesPerByte(proto_t'(modeM2_ff));
  wire endOpOnly = edgeCnt_ff == sysOpEdges;
  wire endOneByte = edgeCnt_ff == (sysOpEdges << 1);
  wire endTwoByte = edgeCnt_ff == (sysOpEdges * 5'h03);
  wire canWrite = welFf & ~busyFf;
  wire hwGuard = ~wpS2_ff & statHiFf[STAT_GUARD_BIT - 2];
  wire protErr = flagFf[FLAG_PROT_ERR_BIT];
  wire [15:0] nvWord = {inSh_ff[7:0], inSh_ff[15:8]};
  wire [15:0] statCycles = 16'(STATUS_WRITE_CYCLES - 1);
  wire [15:0] nvCycles = 16'(NVCFG_WRITE_CYCLES - 1);

  always_comb begin
    nxt_wel = welFf;
    nxt_busy = busyFf;
    nxt_statHi = statHiFf;
    nxt_flag = flagFf;
    nxt_nv = nvFf;
    nxt_v = vFf;
    nxt_ev = evFf;
    nxt_pendNv = pendNvFf;
    nxt_pendVal = pendValFf;
    nxt_timer = timerFf;
    if (busyFf) begin
      nxt_timer = timerFf - 16'h0001;
      if (timerFf == 16'h0000) begin
        nxt_busy = 1'b0;
        if (pendNvFf) nxt_nv = pendValFf;
        else nxt_statHi = pendValFf[7:2];
      end
    end
    if (frameEnd) begin
      unique case (opcode_ff)
        OP_SET_WEL: if (endOpOnly && !busyFf) nxt_wel = 1'b1;
        OP_CLR_WEL: if (endOpOnly && !busyFf && !protErr) nxt_wel = 1'b0;
        OP_CLR_FLAG: if (endOpOnly) begin
          nxt_flag[FLAG_ERASE_ERR_BIT] = 1'b0;
          nxt_flag[FLAG_PROG_ERR_BIT] = 1'b0;
          nxt_flag[FLAG_PROT_ERR_BIT] = 1'b0;
          if (protErr && !busyFf) nxt_wel = 1'b0;
        end
        OP_WR_STAT: if (endOneByte && canWrite) begin
          if (hwGuard) nxt_flag[FLAG_PROT_ERR_BIT] = 1'b1;
          else begin
            nxt_busy = 1'b1;
            nxt_wel = 1'b0;
            nxt_pendNv = 1'b0;
            nxt_pendVal = {8'h00, inSh_ff[7:2], statHiFf[1:0]};
            nxt_timer = statCycles;
          end
        end
        OP_WR_NVCFG: if (endTwoByte && canWrite) begin
          nxt_busy = 1'b1;
          nxt_wel = 1'b0;
          nxt_pendNv = 1'b1;
          nxt_pendVal = nvWord;
          nxt_timer = nvCycles;
        end
        OP_WR_VCFG: if (endOneByte && canWrite) begin
          nxt_v = (vFf & ~VCFG_WR_MASK) | (inSh_ff[7:0] & VCFG_WR_MASK);
          nxt_wel = 1'b0;
        end
        OP_WR_EVCFG: if (endOneByte && canWrite) begin
          nxt_ev = (evFf & ~EVCFG_WR_MASK) | (inSh_ff[7:0] & EVCFG_WR_MASK);
          nxt_wel = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {csS1_ff, csS2_ff, csS3_ff} <= 3'b111;
      {wpS1_ff, wpS2_ff} <= 2'b11;
      {modeM1_ff, modeM2_ff} <= 4'h0;
      welFf <= 1'b0;
      busyFf <= 1'b0;
      statHiFf <= STAT_HI_RESET;
      flagFf <= FLAG_RESET;
      nvFf <= NVCFG_RESET;
      vFf <= VCFG_RESET;
      evFf <= EVCFG_RESET;
      pendNvFf <= 1'b0;
      pendValFf <= 16'h0000;
      timerFf <= 16'h0000;
    end else begin
      {csS1_ff, csS2_ff, csS3_ff} <= {link.csN, csS1_ff, csS2_ff};
      {wpS1_ff, wpS2_ff} <= {writeProtectN, wpS1_ff};
      {modeM1_ff, modeM2_ff} <= {protoMode, modeM1_ff};
      welFf <= nxt_wel;
      busyFf <= nxt_busy;
      statHiFf <= nxt_statHi;
      flagFf <= nxt_flag;
      nvFf <= nxt_nv;
      vFf <= nxt_v;
      evFf <= nxt_ev;
      pendNvFf <= nxt_pendNv;
      pendValFf <= nxt_pendVal;
      timerFf <= nxt_timer;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      statusOut_ff <= 8'h00;
      flagOut_ff <= 8'h00;
      nvCfgOut_ff <= NVCFG_RESET;
      vCfgOut_ff <= VCFG_RESET;
      evCfgOut_ff <= EVCFG_RESET;
    end else begin
      statusOut_ff <= {statHiFf, welFf, busyFf};
      flagOut_ff <= flagFf | ({7'h00, ~busyFf} << FLAG_READY_BIT);
      nvCfgOut_ff <= nvFf | NVCFG_RSVD_MASK;
      vCfgOut_ff <= vFf;
      evCfgOut_ff <= evFf;
    end
  end
endmodule : sfr_device

// ---- hdl/sfr_host.sv ----
// Host-side serial controller that frames register commands onto the link.
`timescale 1ns/1ns
module sfr_host import sfr_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire proto_t protoMode,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [1:0] wrBytes,
  input wire logic [15:0] wrData,
  input wire logic [2:0] rdBytes,
  sfr_link_if.host link,
  output logic idle_ff,
  output logic done_ff,
  output logic [15:0] rdData_ff
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FINISH = 2'b10
  } host_state_t;

  host_state_t state_ff;
  logic csN_ff;
  logic sclk_ff;
  logic [3:0] out_ff;
  logic [3:0] oenN_ff;
  logic [2:0] phase_ff;
  logic [6:0] edge_ff;
  logic [6:0] txEdges_ff;
  logic [6:0] allEdges_ff;
  logic [23:0] txSh_ff;
  logic [3:0] laneS1_ff;
  logic [3:0] laneS2_ff;
  logic [1:0] mode_ff;

  assign link.csN = csN_ff;
  assign link.sclk = sclk_ff;
  assign link.hostOut = out_ff;
  assign link.hostOenN = oenN_ff;

  wire proto_t mode = proto_t'(mode_ff);
  wire [6:0] perByte = {2'b00, edgesPerByte(protoMode)};
  wire [6:0] reqTx = 7'((3'h1 + wrBytes) * perByte);
  wire [6:0] reqAll = 7'((4'h1 + wrBytes + rdBytes) * perByte);
  wire [3:0] w = laneWidth(mode);
  wire [3:0] txBits = (mode == PROTO_QUAD) ? txSh_ff[23:20] :
                      (mode == PROTO_DUAL) ? {2'b00, txSh_ff[23:22]} : {3'b000, txSh_ff[23]};
  wire [23:0] nxt_txSh = txSh_ff << w;
  wire inTx = edge_ff < txEdges_ff;
  wire [3:0] rxLanes = (mode == PROTO_EXT) ? {3'b000, laneS2_ff[1]} : laneS2_ff;
  wire lastDone = (edge_ff == allEdges_ff) && (phase_ff == 3'h0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      laneS1_ff <= 4'hF;
      laneS2_ff <= 4'hF;
    end else begin
      laneS1_ff <= link.lane;
      laneS2_ff <= laneS1_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      csN_ff <= 1'b1;
      sclk_ff <= 1'b0;
      out_ff <= 4'h0;
      oenN_ff <= 4'hF;
      phase_ff <= 3'h0;
      edge_ff <= 7'h00;
      txEdges_ff <= 7'h00;
      allEdges_ff <= 7'h00;
      txSh_ff <= 24'h0;
      mode_ff <= PROTO_EXT;
      idle_ff <= 1'b1;
      done_ff <= 1'b0;
      rdData_ff <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: if (start) begin
          state_ff <= ST_RUN;
          csN_ff <= 1'b0;
          idle_ff <= 1'b0;
          phase_ff <= 3'h0;
          edge_ff <= 7'h00;
          txEdges_ff <= reqTx;
          allEdges_ff <= reqAll;
          txSh_ff <= {opcode, wrData[7:0], wrData[15:8]};
          mode_ff <= protoMode;
          rdData_ff <= 16'h0000;
        end
        ST_RUN: begin
          phase_ff <= phase_ff + 3'h1;
          sclk_ff <= (phase_ff + 3'h1) >= SCLK_RISE_PHASE;
          if (lastDone) begin
            state_ff <= ST_FINISH;
            csN_ff <= 1'b1;
            sclk_ff <= 1'b0;
            oenN_ff <= 4'hF;
          end else if (phase_ff == 3'h0) begin
            out_ff <= txBits;
            oenN_ff <= inTx ? driveEnN(mode) : 4'hF;
          end
          if (phase_ff == SCLK_SAMPLE_PHASE && !inTx) begin
            rdData_ff <= shiftLanes(rdData_ff, rxLanes, mode);
          end
          if ((phase_ff + 3'h1) == SCLK_RISE_PHASE) begin
            edge_ff <= edge_ff + 7'h01;
            txSh_ff <= nxt_txSh;
          end
          // Lanes are let go while the clock is high, before the device turns them round.
          if (phase_ff == (SCLK_RISE_PHASE + 3'h1) && !inTx) begin
            oenN_ff <= 4'hF;
          end
        end
        ST_FINISH: begin
          state_ff <= ST_IDLE;
          idle_ff <= 1'b1;
          done_ff <= 1'b1;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule : sfr_host

// ---- hdl/sfr_link_if.sv ----
// Serial link between host controller and flash command logic.
`timescale 1ns/1ns
interface sfr_link_if;
  logic csN;
  logic sclk;
  logic [3:0] hostOut;
  logic [3:0] hostOenN;
  logic [3:0] devOut;
  logic [3:0] devOenN;
  logic [3:0] lane;

  // Each lane resolves to the driving end, else idles high as with a pull-up.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = !hostOenN[i] ? hostOut[i] : (!devOenN[i] ? devOut[i] : 1'b1);
  end

  modport host(output csN, output sclk, output hostOut, output hostOenN, input lane);
  modport dev(input csN, input sclk, input lane, output devOut, output devOenN);
endinterface : sfr_link_if

// ---- hdl/sfr_pkg.sv ----
// Constants, types and helpers shared by both ends of the register-command link.
package sfr_pkg;
  typedef enum logic [1:0] {
    PROTO_EXT = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } proto_t;

  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_RD_FLAG = 8'h70;
  localparam logic [7:0] OP_RD_NVCFG = 8'hB5;
  localparam logic [7:0] OP_RD_VCFG = 8'h85;
  localparam logic [7:0] OP_RD_EVCFG = 8'h65;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_WR_NVCFG = 8'hB1;
  localparam logic [7:0] OP_WR_VCFG = 8'h81;
  localparam logic [7:0] OP_WR_EVCFG = 8'h61;
  localparam logic [7:0] OP_CLR_FLAG = 8'h50;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_GUARD_BIT = 7;
  localparam int FLAG_READY_BIT = 7;
  localparam int FLAG_ERASE_ERR_BIT = 5;
  localparam int FLAG_PROG_ERR_BIT = 4;
  localparam int FLAG_PROT_ERR_BIT = 1;

  localparam logic [5:0] STAT_HI_RESET = 6'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] NVCFG_RESET = 16'hFFFF;
  localparam logic [7:0] VCFG_RESET = 8'hFF;
  localparam logic [7:0] EVCFG_RESET = 8'hFF;
  localparam logic [15:0] NVCFG_RSVD_MASK = 16'h0000;
  localparam logic [7:0] VCFG_WR_MASK = 8'hFF;
  localparam logic [7:0] EVCFG_WR_MASK = 8'hFF;

  localparam int MCLK_NS = 10;
  localparam int STATUS_WRITE_TIME_NS = 1000;
  localparam int NVCFG_WRITE_TIME_NS = 2000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int NVCFG_WRITE_CYC = (NVCFG_WRITE_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [2:0] SCLK_RISE_PHASE = 3'h4;
  localparam logic [2:0] SCLK_SAMPLE_PHASE = 3'h3;
  localparam logic [4:0] EDGE_CNT_MAX = 5'h1F;

  function automatic logic [3:0] laneWidth(input proto_t m);
    case (m)
      PROTO_DUAL: return 4'h2;
      PROTO_QUAD: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction : laneWidth

  function automatic logic [4:0] edgesPerByte(input proto_t m);
    case (m)
      PROTO_DUAL: return 5'h04;
      PROTO_QUAD: return 5'h02;
      default: return 5'h08;
    endcase
  endfunction : edgesPerByte

  function automatic logic [15:0] shiftLanes(input logic [15:0] v, input logic [3:0] d,
                                             input proto_t m);
    case (m)
      PROTO_DUAL: return {v[13:0], d[1:0]};
      PROTO_QUAD: return {v[11:0], d};
      default: return {v[14:0], d[0]};
    endcase
  endfunction : shiftLanes

  function automatic logic [3:0] driveEnN(input proto_t m);
    case (m)
      PROTO_DUAL: return 4'hC;
      PROTO_QUAD: return 4'h0;
      default: return 4'hE;
    endcase
  endfunction : driveEnN
endpackage : sfr_pkg

// ---- tb/sfr_link_asserts.sv ----
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ns
module sfr_link_asserts import sfr_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire proto_t protoMode,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOenN,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOenN,
  input wire logic [3:0] lane
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic sclkDly_ff;
  logic [4:0] edgeCnt_ff;
  logic [4:0] nxt_edgeCnt;
  logic [4:0] byteMask;
  // Counts serial clock rising edges within one select-low frame.
  assign nxt_edgeCnt = csN ? 5'h00 : ((sclk && !sclkDly_ff) ? edgeCnt_ff + 5'h01 : edgeCnt_ff);
  assign byteMask = edgesPerByte(protoMode) - 5'h01;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclkDly_ff <= 1'b0;
      edgeCnt_ff <= 5'h00;
    end else begin
      sclkDly_ff <= sclk;
      edgeCnt_ff <= nxt_edgeCnt;
    end
  end
  sequence highPhase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence leadIn;
    (!sclk) [*4] ##1 sclk;
  endsequence
  sclk_pulse_a: assert property ($rose(sclk) |-> highPhase)
    else $error("Serial clock high phase is not four cycles.");
  frame_lead_a: assert property ($fell(csN) |-> leadIn)
    else $error("First serial clock edge not four cycles after select.");
  sclk_idle_a: assert property (csN |-> !sclk)
    else $error("Serial clock moves while deselected.");
  dev_release_a: assert property (csN |-> devOenN == 4'hF)
    else $error("Device drives a lane while deselected.");
  idle_lane_a: assert property (csN |-> lane == 4'hF)
    else $error("Lanes not idle high while deselected.");
  no_clash_a: assert property ((hostOenN | devOenN) == 4'hF)
    else $error("Both ends drive one lane.");
  ext_lane_a: assert property (protoMode == PROTO_EXT |-> devOenN[3:2] == 2'h3 && devOenN[0])
    else $error("Device drives a lane other than lane one.");
  byte_whole_a: assert property ($rose(csN) |-> (edgeCnt_ff & byteMask) == 5'h00)
    else $error("Frame ends off a byte boundary.");
  data_hold_a: assert property (sclk && $past(sclk) |-> $stable(hostOut) && $stable(devOut | devOenN))
    else $error("Lane data changes while serial clock is high.");
endmodule : sfr_link_asserts

// ---- tb/test_serial_flash_register_commands.sv ----
// Testbench joining host and device ends over the serial link.
`timescale 1ns/1ns
module test_serial_flash_register_commands import sfr_pkg::*; ;
  localparam int SW_CYC = 200;
  localparam int NV_CYC = 250;
  logic mclk, rst, start, writeProtectN, idle, done;
  proto_t protoMode;
  logic [7:0] opcode, statusOut, flagOut, vCfgOut, evCfgOut, vb;
  logic [1:0] wrBytes;
  logic [15:0] wrData, rdData, nvCfgOut, nv;
  logic [2:0] rdBytes;
  int fails = 0;
  int total_checks = 0;
  sfr_link_if link();
  sfr_host i_sfr_host(.mclk(mclk), .rst(rst), .protoMode(protoMode), .start(start),
    .opcode(opcode), .wrBytes(wrBytes), .wrData(wrData), .rdBytes(rdBytes), .link(link.host),
    .idle_ff(idle), .done_ff(done), .rdData_ff(rdData));
  sfr_device #(.STATUS_WRITE_CYCLES(SW_CYC), .NVCFG_WRITE_CYCLES(NV_CYC)) i_sfr_device(
    .mclk(mclk), .rst(rst), .protoMode(protoMode), .writeProtectN(writeProtectN),
    .link(link.dev), .statusOut_ff(statusOut), .flagOut_ff(flagOut), .nvCfgOut_ff(nvCfgOut),
    .vCfgOut_ff(vCfgOut), .evCfgOut_ff(evCfgOut));
  sfr_link_asserts i_sfr_link_asserts(.mclk(mclk), .rst(rst), .protoMode(protoMode),
    .csN(link.csN), .sclk(link.sclk), .hostOut(link.hostOut), .hostOenN(link.hostOenN),
    .devOut(link.devOut), .devOenN(link.devOenN), .lane(link.lane));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Runs one host frame and leaves the link deselected long enough to settle.
  task automatic xfer(input logic [7:0] op, input logic [1:0] wb, input logic [15:0] wd,
                      input logic [2:0] rb);
    int n;
    opcode = op;
    wrBytes = wb;
    wrData = wd;
    rdBytes = rb;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    chk({15'h0000, idle}, 16'h0000);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk({14'h0000, idle, done}, 16'h0003);
    repeat (6) @(negedge mclk);
  endtask : xfer

  task automatic wel();
    xfer(OP_SET_WEL, 2'h0, 16'h0000, 3'h0);
  endtask : wel

  // Waits for the busy bit to drop and checks how long it stayed up.
  task automatic waitReady(input int lo, input int hi);
    int n;
    n = 0;
    while (statusOut[STAT_BUSY_BIT] !== 1'b0 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    chk({15'h0000, (n >= lo && n <= hi)}, 16'h0001);
    repeat (2) @(negedge mclk);
  endtask : waitReady

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    wrBytes = 2'h0;
    wrData = 16'h0000;
    rdBytes = 3'h0;
    protoMode = PROTO_EXT;
    writeProtectN = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk({statusOut, flagOut}, 16'h0080);
    chk({vCfgOut, evCfgOut}, 16'hFFFF);
    for (logic [1:0] i = 2'h0; i < 2'h3; i++) begin
      protoMode = proto_t'(i);
      vb = {6'h29, i};
      nv = {vb ^ 8'h0F, vb};
      repeat (4) @(negedge mclk);
      xfer(OP_SET_WEL, 2'h1, 16'h0000, 3'h0);
      chk({8'h00, statusOut}, 16'h0000);
      wel();
      chk({8'h00, statusOut}, 16'h0002);
      xfer(OP_RD_STAT, 2'h0, 16'h0000, 3'h2);
      chk(rdData, 16'h0202);
      xfer(OP_CLR_WEL, 2'h0, 16'h0000, 3'h0);
      chk({8'h00, statusOut}, 16'h0000);
      wel();
      xfer(OP_WR_VCFG, 2'h1, {8'h00, vb}, 3'h0);
      wel();
      xfer(OP_WR_EVCFG, 2'h1, {8'h00, ~vb}, 3'h0);
      chk({vCfgOut, evCfgOut}, {vb, ~vb});
      xfer(OP_RD_VCFG, 2'h0, 16'h0000, 3'h2);
      chk(rdData, {vb, vb});
      xfer(OP_RD_EVCFG, 2'h0, 16'h0000, 3'h2);
      chk(rdData, {~vb, ~vb});
      wel();
      xfer(OP_WR_NVCFG, 2'h2, nv, 3'h0);
      chk({8'h00, statusOut} & 16'h0001, 16'h0001);
      waitReady(NV_CYC - 12, NV_CYC);
      chk(nvCfgOut, nv);
      chk({8'h00, statusOut}, 16'h0000);
      xfer(OP_RD_NVCFG, 2'h0, 16'h0000, 3'h2);
      chk(rdData, {nv[7:0], nv[15:8]});
      xfer(OP_RD_NVCFG, 2'h0, 16'h0000, 3'h3);
      chk(rdData, {nv[15:8], 8'h00});
      wel();
      xfer(OP_WR_STAT, 2'h2, 16'h00FC, 3'h0);
      chk({statusOut, flagOut}, 16'h0280);
      xfer(OP_WR_STAT, 2'h1, 16'h00FF, 3'h0);
      xfer(OP_RD_STAT, 2'h0, 16'h0000, 3'h1);
      chk({15'h0000, rdData[STAT_BUSY_BIT]}, 16'h0001);
      waitReady(0, SW_CYC);
      chk({statusOut, flagOut}, 16'hFC80);
      writeProtectN = 1'b0;
      wel();
      xfer(OP_WR_STAT, 2'h1, 16'h0000, 3'h0);
      chk({statusOut, flagOut}, 16'hFE82);
      xfer(OP_CLR_WEL, 2'h0, 16'h0000, 3'h0);
      chk({8'h00, statusOut}, 16'h00FE);
      xfer(OP_CLR_FLAG, 2'h0, 16'h0000, 3'h0);
      chk({statusOut, flagOut}, 16'hFC80);
      writeProtectN = 1'b1;
      wel();
      xfer(OP_WR_STAT, 2'h1, 16'h0000, 3'h0);
      waitReady(SW_CYC - 12, SW_CYC);
      chk({statusOut, flagOut}, 16'h0080);
    end
    tally_and_finish();
  end
endmodule : test_serial_flash_register_commands
